// *** src/ckgcr_regs.sv ***
// Operation
// - byte 0 bit 2 enables differential output
// - byte 2 bit 7 picks down-spread amount
// - byte 2 bit 2 switches spread modulation
// - byte 6 bit 6 enters test clock
// - byte 6 bit 7: divided reference or off
// - byte 7 reads revision and vendor code
// - all bytes take power-up values at reset
// - command byte: mode, select 00, offset
// - respond only to address d2
// - block transfers ascend, may stop anywhere
`timescale 1ns/1ps
module ckgcr_regs
  import ckgcr_pkg::*;
#(
  parameter logic [3:0] REV_CODE    = 4'h5, // arbitrary
  parameter logic [3:0] VENDOR_CODE = 4'ha, // arbitrary
  parameter int         REF_DIV     = REF_DIV_DEFAULT
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic serialDataPinIn,
  output logic      serialDataPinOut,
  output logic      serialDataPinOe,
  output logic      diffOutputEnable,
  output logic      diffOutOe,
  output logic      diffOutTestClkSel,
  output logic      refDivClk,
  output logic      spreadModulationEnable,
  output logic      downSpreadAmountSelect,
  output logic      testModeActive
);

  typedef struct packed {
    ckgcr_phase_t     phase;
    logic             sclPrev;
    logic             sdaPrev;
    logic [3:0]       bitCnt;
    logic [7:0]       shReg;
    logic [7:0]       txReg;
    logic             ackDrv;
    logic             drvData;
    logic             blockMode;
    logic             rdCount;
    logic [4:0]       ptr;
    logic [6:0][7:0]  regs;
  } ckgcr_state_t;

  localparam logic [7:0] IDENT = {REV_CODE, VENDOR_CODE};

  ckgcr_state_t s_r;
  ckgcr_state_t s_nxt;

  logic sdaIn;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic testSel;
  logic cmdCsOk;
  logic addrMatch;

  assign sdaIn     = serialDataPinIn;
  assign sclRise   = !s_r.sclPrev && scl;
  assign sclFall   = s_r.sclPrev && !scl;
  assign startSeen = s_r.sclPrev && scl && s_r.sdaPrev && !sdaIn;
  assign stopSeen  = s_r.sclPrev && scl && !s_r.sdaPrev && sdaIn;
  assign addrMatch = s_r.shReg[7:1] == DEV_ADDR[7:1];
  assign cmdCsOk   = s_r.shReg[CMD_CS_HI:CMD_CS_LO] == 2'b00;

  function automatic logic [7:0] rd_byte(input logic [6:0][7:0] regs,
                                         input logic [4:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx < IDX_IDENT) begin
      v = regs[idx[2:0]];
    end else if (idx == IDX_IDENT) begin
      v = IDENT;
    end
    return v;
  endfunction

  always_comb begin
    s_nxt         = s_r;
    s_nxt.sclPrev = scl;
    s_nxt.sdaPrev = sdaIn;
    if (startSeen) begin
      // repeated start keeps command, offset and mode
      s_nxt.phase   = PH_ADDR;
      s_nxt.bitCnt  = 4'h0;
      s_nxt.ackDrv  = 1'b0;
      s_nxt.drvData = 1'b0;
    end else if (stopSeen) begin
      s_nxt.phase   = PH_IDLE;
      s_nxt.bitCnt  = 4'h0;
      s_nxt.ackDrv  = 1'b0;
      s_nxt.drvData = 1'b0;
    end else if (s_r.phase != PH_IDLE && s_r.phase != PH_IGNORE) begin
      if (sclRise) begin
        if (s_r.bitCnt < BITS_PER_BYTE) begin
          s_nxt.shReg  = {s_r.shReg[6:0], sdaIn};
          s_nxt.bitCnt = 4'(s_r.bitCnt + 1'b1);
        end else if (s_r.bitCnt == ACK_SLOT) begin
          s_nxt.bitCnt = ACK_DONE;
          // controller not-acknowledge ends a read
          if (s_r.phase == PH_RDATA && !s_r.ackDrv && sdaIn) begin
            s_nxt.phase = PH_IGNORE;
          end
        end
      end else if (sclFall) begin
        if (s_r.phase == PH_RDATA && !s_r.ackDrv &&
            s_r.bitCnt != 4'h0 && s_r.bitCnt < BITS_PER_BYTE) begin
          s_nxt.txReg = {s_r.txReg[6:0], 1'b0};
        end else if (s_r.bitCnt == ACK_SLOT) begin
          case (s_r.phase)
            PH_RDATA: begin
              s_nxt.drvData = 1'b0;
            end
            PH_ADDR: begin
              if (addrMatch) begin
                s_nxt.ackDrv = 1'b1;
                if (s_r.shReg[0]) begin
                  s_nxt.phase = PH_RDATA;
                  if (s_r.blockMode) begin
                    s_nxt.txReg   = BLOCK_COUNT;
                    s_nxt.rdCount = 1'b1;
                  end else begin
                    s_nxt.txReg   = rd_byte(s_r.regs, s_r.ptr);
                    s_nxt.rdCount = 1'b0;
                  end
                end else begin
                  s_nxt.phase = PH_CMD;
                end
              end else begin
                s_nxt.phase = PH_IGNORE;
              end
            end
            PH_CMD: begin
              if (cmdCsOk) begin
                s_nxt.ackDrv    = 1'b1;
                s_nxt.blockMode = !s_r.shReg[CMD_BYTE_BIT];
                // block access always starts at byte 0
                s_nxt.ptr = s_r.shReg[CMD_BYTE_BIT] ?
                            s_r.shReg[CMD_OFS_HI:0] : 5'h00;
                s_nxt.phase = s_r.shReg[CMD_BYTE_BIT] ? PH_WDATA : PH_WCNT;
              end else begin
                s_nxt.phase = PH_IGNORE;
              end
            end
            PH_WCNT: begin
              // count is not enforced: a block may stop after any byte
              s_nxt.ackDrv = 1'b1;
              s_nxt.phase  = PH_WDATA;
            end
            PH_WDATA: begin
              s_nxt.ackDrv = 1'b1;
              if (s_r.ptr < IDX_IDENT) begin
                s_nxt.regs[s_r.ptr[2:0]] = s_r.shReg;
              end
              if (s_r.blockMode) begin
                s_nxt.ptr = 5'(s_r.ptr + 1'b1);
              end
            end
            default: begin
              s_nxt.phase = PH_IGNORE;
            end
          endcase
        end else if (s_r.bitCnt == ACK_DONE) begin
          s_nxt.ackDrv = 1'b0;
          s_nxt.bitCnt = 4'h0;
          if (s_r.phase == PH_RDATA) begin
            s_nxt.drvData = 1'b1;
            if (!s_r.ackDrv) begin
              if (s_r.rdCount) begin
                s_nxt.rdCount = 1'b0;
                s_nxt.txReg   = rd_byte(s_r.regs, s_r.ptr);
              end else begin
                s_nxt.ptr   = 5'(s_r.ptr + 1'b1);
                s_nxt.txReg = rd_byte(s_r.regs, 5'(s_r.ptr + 1'b1));
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.phase <= PH_IDLE;
      s_r.regs  <= CFG_PUP;
      s_r.sclPrev <= 1'b1;
      s_r.sdaPrev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open drain: only ever pull low
  assign serialDataPinOut = 1'b0;
  assign serialDataPinOe  = s_r.ackDrv || (s_r.drvData && !s_r.txReg[7]);

  assign testModeActive = s_r.regs[IDX_TEST][TEST_MODE_BIT];
  assign testSel        = s_r.regs[IDX_TEST][TEST_SEL_BIT];
  assign diffOutputEnable = s_r.regs[IDX_OUT_EN][OE_BIT];
  // test mode overrides the normal enable
  assign diffOutOe = testModeActive ? testSel : diffOutputEnable;
  assign diffOutTestClkSel = testModeActive && testSel;
  assign spreadModulationEnable =
    s_r.regs[IDX_SPREAD][SPREAD_EN_BIT];
  assign downSpreadAmountSelect =
    s_r.regs[IDX_SPREAD][SPREAD_AMT_BIT];

  ckgcr_ref_div #(
    .DIV (REF_DIV)
  ) u_ref_div (
    .clk       (clk),
    .rst       (rst),
    .enable    (diffOutTestClkSel),
    .refDivClk (refDivClk)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence addrByteEnd;
    s_r.phase == PH_ADDR && sclFall && s_r.bitCnt == ACK_SLOT;
  endsequence

  sequence cmdByteEnd;
    s_r.phase == PH_CMD && sclFall && s_r.bitCnt == ACK_SLOT;
  endsequence

  chk_oe_normal_gate: assert property (
    s_r.phase == PH_WDATA && sclFall && s_r.bitCnt == ACK_SLOT &&
      s_r.ptr == IDX_OUT_EN && !testModeActive
      |=> diffOutOe == $past(s_r.shReg[OE_BIT]))
    else $error("output enable does not follow byte 0 bit 2");

  chk_pup_values: assert property (
    $fell(rst) |-> diffOutOe && downSpreadAmountSelect &&
      !spreadModulationEnable && !testModeActive)
    else $error("power-up controls wrong");

  chk_spread_hold: assert property (
    !(s_r.phase == PH_WDATA && sclFall && s_r.bitCnt == ACK_SLOT)
      |=> $stable(downSpreadAmountSelect) && $stable(spreadModulationEnable))
    else $error("spread controls changed without a data byte");

  chk_test_hiz: assert property (
    testModeActive && !testSel |-> !diffOutOe && !diffOutTestClkSel)
    else $error("test mode high impedance not honoured");

  chk_test_ref: assert property (
    testModeActive && testSel |-> diffOutOe && diffOutTestClkSel)
    else $error("test mode divided reference not selected");

  // the byte about to be shifted out for offset 7 must be the fixed code
  chk_ident_read: assert property (
    s_r.phase == PH_RDATA && s_r.drvData && s_r.bitCnt == 4'h0 &&
      s_r.ptr == IDX_IDENT && !s_r.rdCount |-> s_r.txReg == IDENT)
    else $error("identification byte wrong");

  chk_addr_ack: assert property (
    addrByteEnd |=> s_r.ackDrv == $past(addrMatch) ##1
      (s_r.ackDrv || s_r.phase != PH_ADDR))
    else $error("address acknowledge wrong");

  chk_cs_reject: assert property (
    cmdByteEnd ##0 !cmdCsOk |=> s_r.phase == PH_IGNORE && !serialDataPinOe)
    else $error("command with nonzero select was accepted");

  chk_block_ptr: assert property (
    s_r.phase == PH_WDATA && sclFall && s_r.bitCnt == ACK_SLOT &&
      s_r.blockMode |=> s_r.ptr == 5'($past(s_r.ptr) + 1'b1))
    else $error("block write did not advance by one byte");

  chk_ref_idle: assert property (
    !diffOutTestClkSel |=> !refDivClk)
    else $error("divided reference runs outside its test mode");

  chk_sda_stable: assert property (
    s_r.sclPrev && scl && !startSeen && !stopSeen
      |=> $stable(serialDataPinOe))
    else $error("data pin changed while clock high");

endmodule

// *** src/ckgcr_pkg.sv ***
package ckgcr_pkg;

  // two-wire link framing
  localparam logic [7:0] DEV_ADDR      = 8'hd2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [3:0] ACK_DONE      = 4'h9;
  localparam logic [7:0] BLOCK_COUNT   = 8'h08;

  // command byte fields
  localparam int CMD_BYTE_BIT = 7;
  localparam int CMD_CS_HI    = 6;
  localparam int CMD_CS_LO    = 5;
  localparam int CMD_OFS_HI   = 4;

  // register indices
  localparam logic [4:0] IDX_OUT_EN = 5'h00;
  localparam logic [4:0] IDX_SPREAD = 5'h02;
  localparam logic [4:0] IDX_TEST   = 5'h06;
  localparam logic [4:0] IDX_IDENT  = 5'h07;
  localparam int         NUM_RW     = 7;

  // field positions
  localparam int OE_BIT         = 2;
  localparam int SPREAD_AMT_BIT = 7;
  localparam int SPREAD_EN_BIT  = 2;
  localparam int TEST_MODE_BIT  = 6;
  localparam int TEST_SEL_BIT   = 7;

  // power-up values of bytes 0..6, byte 0 in the low slot
  localparam logic [6:0][7:0] CFG_PUP = {
    8'h13, 8'h00, 8'h01, 8'haf, 8'hea, 8'h00, 8'h7c
  };

  // divided reference ratio for test clock mode
  localparam int REF_DIV_DEFAULT = 4;

  typedef enum logic [6:0] {
    PH_IDLE   = 7'h01,
    PH_ADDR   = 7'h02,
    PH_CMD    = 7'h04,
    PH_WCNT   = 7'h08,
    PH_WDATA  = 7'h10,
    PH_RDATA  = 7'h20,
    PH_IGNORE = 7'h40
  } ckgcr_phase_t;

endpackage

// *** src/ckgcr_ref_div.sv ***
`timescale 1ns/1ps
module ckgcr_ref_div
  import ckgcr_pkg::*;
#(
  parameter int DIV = REF_DIV_DEFAULT
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  output logic      refDivClk
);

  if (DIV < 2) begin : g_bad_div
    $error("ckgcr_ref_div: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } ckgcr_div_t;

  ckgcr_div_t s_r;
  ckgcr_div_t s_nxt;

  // odd ratios give a duty cycle one count off half
  always_comb begin
    s_nxt = s_r;
    if (!enable) begin
      s_nxt = '0;
    end else if (s_r.cnt == CW'(DIV - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.out = 1'b1;
    end else begin
      s_nxt.cnt = CW'(s_r.cnt + 1'b1);
      if (s_r.cnt == CW'(DIV / 2 - 1)) begin
        s_nxt.out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign refDivClk = s_r.out;

endmodule

// *** sim/ckgcr_ctrl_model.sv ***
`timescale 1ns/1ps
module ckgcr_ctrl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask
  // data is released before scl rises, so this also serves as repeated start
  task automatic start();
    sdaLow = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sdaLow = 1'b1;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sdaLow = 1'b0;
    hold();
  endtask
  // eight bits msb first, then the acknowledge slot at level ackLvl
  task automatic xfer(input logic [7:0] d, input logic ackLvl,
                      output logic [7:0] q, output logic ackIn);
    logic [8:0] bits;
    bits = {d, ackLvl};
    for (int i = 8; i >= 0; i--) begin
      sdaLow = ~bits[i];
      hold();
      scl = 1'b1;
      hold();
      if (i > 0) q[i-1] = sda;
      else ackIn = ~sda;
      scl = 1'b0;
    end
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ckgcr_pkg::*;
  localparam logic [7:0] IDENT = 8'h3c; // arbitrary codes
  logic       clk, rst, scl, sdaLow, sda, sdOut, sdOe;
  logic       oeEn, pairOe, tSel, refClk, spr, amt, tMode, a, last;
  logic [7:0] q;
  logic [7:0] shadow [8];
  logic [7:0] tcv [3] = '{8'h53, 8'hd3, 8'h13};
  int         err_total = 0, samples_checked = 0, cyc = 0, n;
  // open drain with pull-up
  assign sda = ~(sdaLow | (sdOe & ~sdOut));
  ckgcr_regs #(.REV_CODE(4'h3), .VENDOR_CODE(4'hc), .REF_DIV(4)) uut (
    .clk(clk), .rst(rst), .scl(scl), .serialDataPinIn(sda),
    .serialDataPinOut(sdOut), .serialDataPinOe(sdOe),
    .diffOutputEnable(oeEn), .diffOutOe(pairOe),
    .diffOutTestClkSel(tSel), .refDivClk(refClk),
    .spreadModulationEnable(spr), .downSpreadAmountSelect(amt),
    .testModeActive(tMode));
  ckgcr_ctrl_model ctrl (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic put(input logic [7:0] d, input logic expAck);
    ctrl.xfer(d, 1'b1, q, a);
    chk1(a, expAck);
  endtask
  task automatic wr(input logic [4:0] ofs, input logic [7:0] d);
    if (ofs < 5'h07) shadow[ofs] = d;
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put({3'b100, ofs}, 1'b1);
    put(d, 1'b1);
    ctrl.stop();
  endtask
  task automatic rd(input logic [4:0] ofs);
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put({3'b100, ofs}, 1'b1);
    ctrl.start();
    put(DEV_ADDR | 8'h01, 1'b1);
    ctrl.xfer(8'hff, 1'b1, q, a);
    chk8(q, shadow[ofs[2:0]]);
    ctrl.stop();
  endtask
  task automatic rdBlk();
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put(8'h00, 1'b1);
    ctrl.start();
    put(DEV_ADDR | 8'h01, 1'b1);
    ctrl.xfer(8'hff, 1'b0, q, a);
    chk8(q, BLOCK_COUNT);
    for (int i = 0; i < 8; i++) begin
      ctrl.xfer(8'hff, i == 7, q, a);
      chk8(q, shadow[i]);
    end
    ctrl.stop();
  endtask
  // stopping after byte n-1 leaves the higher bytes untouched
  task automatic wrBlk(input int cnt);
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put(8'h00, 1'b1);
    put(8'(cnt), 1'b1);
    for (int i = 0; i < cnt; i++) put(shadow[i], 1'b1);
    ctrl.stop();
  endtask
  task automatic outs();
    chk1(oeEn, shadow[0][2]);
    chk1(pairOe, shadow[6][6] ? shadow[6][7] : shadow[0][2]);
    chk1(tSel, shadow[6][6] & shadow[6][7]);
    chk1(amt, shadow[2][7]);
    chk1(spr, shadow[2][2]);
    chk1(tMode, shadow[6][6]);
    chk1(sdOut, 1'b0);
  endtask
  task automatic doReset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    shadow = '{8'h7c, 8'h00, 8'hea, 8'haf, 8'h01, 8'h00, 8'h13, IDENT};
    repeat (2) @(negedge clk);
    outs();
    chk1(refClk, 1'b0);
    rdBlk();
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    doReset();
    wr(5'h00, 8'h78);
    outs();
    rd(5'h00);
    for (int i = 0; i < 4; i++) begin
      wr(5'h02, 8'h6a | {i[1], 4'h0, i[0], 2'h0});
      outs();
    end
    wr(5'h00, 8'h7c);
    foreach (tcv[k]) begin
      wr(5'h06, tcv[k]);
      outs();
      n = 0;
      last = refClk;
      repeat (16) @(negedge clk) begin
        if (refClk === 1'b1 && last === 1'b0) n++;
        last = refClk;
      end
      chk8(8'(n), (tcv[k][7] & tcv[k][6]) ? 8'h04 : 8'h00);
    end
    wr(5'h07, 8'hff);
    rd(5'h07);
    foreach (tcv[k]) begin
      ctrl.start();
      put(k == 0 ? 8'hd4 : 8'h52, 1'b0);
      ctrl.stop();
    end
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put(8'ha0, 1'b0);
    ctrl.stop();
    ctrl.start();
    put(DEV_ADDR, 1'b1);
    put(8'hc0, 1'b0);
    ctrl.stop();
    shadow[0] = 8'h78;
    shadow[1] = 8'h00;
    shadow[2] = 8'hee;
    wrBlk(3);
    outs();
    rdBlk();
    doReset();
    complete_run();
  end
endmodule
